// file: logic/ssi_regs.vh
`ifndef SSI_REGS_VH
`define SSI_REGS_VH
// Millisecond tick in 10 ns clock cycles, then second and minute lengths.
`define SSI_TICK_CYC    17'h186A0
`define SSI_MS_PER_S    10'h3E8
`define SSI_S_PER_MIN   11'h03C
// Power save, indication and fault retry timing.
`define SSI_MOTOR_MIN   11'h01E
`define SSI_SLEEP_S     4'hF
`define SSI_BEEP_MS     9'd100
`define SSI_GAP_MS      9'd100
`define SSI_PAUSE_MS    9'd300
`define SSI_FLASH_MS    9'd100
`define SSI_BLINK_MS    9'd250
`define SSI_RETRY_MS    9'd500
`define SSI_RETRY_MAX   2'h3
// Step durations.
`define SSI_D_BEEP      2'h0
`define SSI_D_GAP       2'h1
`define SSI_D_PAUSE     2'h2
// Tone codes; selectable tones are 0 to 7, 7 being silence.
`define SSI_TONE_SILENT 4'h7
`define SSI_TONE_HIGH   4'h8
`define SSI_TONE_LOW    4'h9
`define SSI_TONE_BUZZ   4'hA
`define SSI_TONE_SWEEP  4'hB
// Beep patterns; a higher code wins arbitration.
`define SSI_P_GOOD      3'h0
`define SSI_P_PWR       3'h1
`define SSI_P_TRI       3'h2
`define SSI_P_ONE       3'h3
`define SSI_P_DESC      3'h4
`define SSI_P_ASC       3'h5
`define SSI_P_RAZ1      3'h6
`define SSI_P_RAZ2      3'h7
// Top states.
`define SSI_ST_BOOT     2'h0
`define SSI_ST_RUN      2'h1
`define SSI_ST_FAIL     2'h2
// Fault handler states.
`define SSI_F_OK        2'h0
`define SSI_F_RETRY     2'h1
`define SSI_F_DOWN      2'h2
// Diagnostic display codes, two BCD digits.
`define SSI_DIAG_NONE   8'h00
`define SSI_DIAG_CFG    8'h05
`define SSI_DIAG_LASER  8'h21
`define SSI_DIAG_MOTOR  8'h31
// Volume levels.
`define SSI_VOL_MAX     2'h2
`endif

// file: logic/ssi_ctrl.v
`include "ssi_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ssi_ctrl #(
    parameter [16:0] TICK_CYC = `SSI_TICK_CYC,
    parameter [9:0]  MS_PER_S = `SSI_MS_PER_S
) (
    input  wire       mclk,
    input  wire       rst,
    input  wire       selftest_done,
    input  wire       selftest_elec_fail,
    input  wire       selftest_nvm_fail,
    input  wire       good_read,
    input  wire       beep_on_read_en,
    input  wire       cfg_mode,
    input  wire       prog_mode,
    input  wire       invalid_code,
    input  wire       host_timeout,
    input  wire       host_timeout_beep_en,
    input  wire       one_code_ok,
    input  wire       flash_main,
    input  wire       flash_cop,
    input  wire       data_pending,
    input  wire       host_ready,
    input  wire       host_wait,
    input  wire       sleep_mode,
    input  wire       ir_motion,
    input  wire [15:0] idle_limit_s,
    input  wire [2:0] tone_sel,
    input  wire [1:0] vol_sel,
    input  wire [1:0] sub_fault,
    input  wire [1:0] fault_clear,
    input  wire [7:0] ext_diag_code,
    output reg        led_white_ff,
    output reg        led_blue_ff,
    output reg        beep_en_ff,
    output reg  [3:0] beep_tone_ff,
    output reg  [1:0] beep_vol_ff,
    output reg        laser_en_ff,
    output reg        motor_en_ff,
    output reg  [1:0] recover_ff,
    output reg  [1:0] sub_off_ff,
    output reg  [7:0] diag_code_ff,
    output reg        scan_en_ff
);
    localparam [10:0] MOTOR_S = `SSI_MOTOR_MIN * `SSI_S_PER_MIN;
    localparam [3:0]  SLEEP_S = `SSI_SLEEP_S;

    // Step word: last, sound, tone[3:0], duration[1:0].
    function [7:0] step;
        input [2:0] pat;
        input [2:0] idx;
        input [3:0] sel;
        begin
            case (pat)
                `SSI_P_GOOD, `SSI_P_PWR: step = {2'b11, sel, `SSI_D_BEEP};
                `SSI_P_TRI: step = {idx == 3'h4, ~idx[0], sel,
                                    idx[0] ? `SSI_D_GAP : `SSI_D_BEEP};
                `SSI_P_ONE: begin
                    if (idx < 3'h5)
                        step = {1'b0, ~idx[0], sel, idx[0] ? `SSI_D_GAP : `SSI_D_BEEP};
                    else if (idx == 3'h5)
                        step = {2'b00, `SSI_TONE_SILENT, `SSI_D_PAUSE};
                    else if (idx == 3'h6)
                        step = {2'b01, `SSI_TONE_HIGH, `SSI_D_BEEP};
                    else
                        step = {2'b11, `SSI_TONE_LOW, `SSI_D_BEEP};
                end
                `SSI_P_DESC: step = {idx == 3'h3, 1'b1,
                                     `SSI_TONE_SWEEP + 4'h3 - {2'b00, idx[1:0]}, `SSI_D_BEEP};
                `SSI_P_ASC: step = {idx == 3'h3, 1'b1,
                                    `SSI_TONE_SWEEP + {2'b00, idx[1:0]}, `SSI_D_BEEP};
                `SSI_P_RAZ1: step = {2'b11, `SSI_TONE_BUZZ, `SSI_D_BEEP};
                `SSI_P_RAZ2: step = {idx == 3'h2, ~idx[0], `SSI_TONE_BUZZ,
                                     idx[0] ? `SSI_D_GAP : `SSI_D_BEEP};
                default: step = {2'b10, `SSI_TONE_SILENT, `SSI_D_BEEP};
            endcase
        end
    endfunction

    function [8:0] dur_ms;
        input [1:0] d;
        begin
            case (d)
                `SSI_D_GAP:   dur_ms = `SSI_GAP_MS;
                `SSI_D_PAUSE: dur_ms = `SSI_PAUSE_MS;
                default:      dur_ms = `SSI_BEEP_MS;
            endcase
        end
    endfunction

    reg  [16:0] tick_cnt_ff;
    reg         ms_tick_ff;
    reg  [9:0]  ms_cnt_ff;
    reg         sec_tick_ff;
    reg  [1:0]  st_ff;
    reg  [7:0]  pend_ff;
    reg         bp_busy_ff;
    reg  [2:0]  bp_pat_ff;
    reg  [2:0]  bp_idx_ff;
    reg  [8:0]  bp_ms_ff;
    reg  [8:0]  gr_ms_ff;
    reg  [8:0]  blink_ms_ff;
    reg         blink_ff;
    reg  [3:0]  sl_sec_ff;
    reg  [15:0] idle_s_ff;
    reg  [10:0] motor_s_ff;
    reg         nvm_err_ff;
    reg         cfg_d_ff;
    reg  [1:0]  flt_st_ff [0:1];
    reg  [1:0]  flt_try_ff [0:1];
    reg  [8:0]  flt_ms_ff [0:1];
    reg  [7:0]  req;
    reg  [2:0]  pick;
    reg  [7:0]  cur;
    reg         nxt_white;
    reg         nxt_blue;
    integer     i;
    integer     j;

    wire run      = (st_ff == `SSI_ST_RUN);
    wire laser_f  = (flt_st_ff[0] != `SSI_F_OK);
    wire motor_f  = (flt_st_ff[1] != `SSI_F_OK);
    wire lasers_on = laser_en_ff && !sub_off_ff[0];
    wire [3:0] sel4 = {1'b0, tone_sel};

    // Indication requests; each becomes a pending bit until its pattern starts.
    always @* begin
        req = 8'h00;
        if (run) begin
            req[`SSI_P_GOOD] = good_read && beep_on_read_en;
            req[`SSI_P_TRI]  = (cfg_mode != cfg_d_ff) ||
                               (host_timeout && host_timeout_beep_en);
            req[`SSI_P_ONE]  = one_code_ok;
            req[`SSI_P_DESC] = flash_main;
            req[`SSI_P_ASC]  = flash_cop;
            req[`SSI_P_RAZ1] = (sub_fault[0] && flt_st_ff[0] == `SSI_F_OK) ||
                               (prog_mode && invalid_code);
            req[`SSI_P_RAZ2] = sub_fault[1] && flt_st_ff[1] == `SSI_F_OK;
        end
        if (st_ff == `SSI_ST_BOOT && selftest_done && !selftest_elec_fail) begin
            req[`SSI_P_PWR] = 1'b1;
            req[`SSI_P_TRI] = selftest_nvm_fail;
        end
    end

    // Highest pending pattern wins; faults sit at the top codes.
    always @* begin
        pick = 3'h0;
        for (j = 0; j < 8; j = j + 1)
            if (pend_ff[j])
                pick = j[2:0];
        cur = step(bp_pat_ff, bp_idx_ff, sel4);
    end

    // Lamp arbitration, sleep and laser-off darkness before fault before cfg/prog mode before per-scan feedback.
    always @* begin
        nxt_white = 1'b0;
        nxt_blue  = 1'b0;
        if (!run) begin
            nxt_white = 1'b0;
            nxt_blue  = 1'b0;
        end else if (sleep_mode) begin
            nxt_white = (sl_sec_ff == 4'h0) && (ms_cnt_ff < {1'b0, `SSI_FLASH_MS});
            nxt_blue  = nxt_white;
        end else if (!lasers_on) begin
            nxt_white = 1'b0;
            nxt_blue  = 1'b0;
        end else if (motor_f) begin
            nxt_white = blink_ff;
            nxt_blue  = blink_ff;
        end else if (laser_f || diag_code_ff != `SSI_DIAG_NONE) begin
            nxt_blue  = blink_ff;
        end else if (cfg_mode) begin
            nxt_white = blink_ff;
            nxt_blue  = blink_ff;
        end else if (prog_mode) begin
            nxt_blue  = blink_ff;
            nxt_white = ~blink_ff;
        end else if (host_wait) begin
            nxt_white = 1'b1;
        end else begin
            nxt_blue  = 1'b1;
            nxt_white = (bp_busy_ff && bp_pat_ff == `SSI_P_PWR) ||
                        (data_pending && !host_ready) ||
                        (gr_ms_ff != 9'h000);
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            tick_cnt_ff  <= 17'h00000;
            ms_tick_ff   <= 1'b0;
            ms_cnt_ff    <= 10'h000;
            sec_tick_ff  <= 1'b0;
            st_ff        <= `SSI_ST_BOOT;
            pend_ff      <= 8'h00;
            bp_busy_ff   <= 1'b0;
            bp_pat_ff    <= 3'h0;
            bp_idx_ff    <= 3'h0;
            bp_ms_ff     <= 9'h000;
            gr_ms_ff     <= 9'h000;
            blink_ms_ff  <= 9'h000;
            blink_ff     <= 1'b0;
            sl_sec_ff    <= 4'h0;
            idle_s_ff    <= 16'h0000;
            motor_s_ff   <= 11'h000;
            nvm_err_ff   <= 1'b0;
            cfg_d_ff     <= 1'b0;
            led_white_ff <= 1'b0;
            led_blue_ff  <= 1'b0;
            beep_en_ff   <= 1'b0;
            beep_tone_ff <= 4'h0;
            beep_vol_ff  <= 2'h0;
            laser_en_ff  <= 1'b0;
            motor_en_ff  <= 1'b0;
            recover_ff   <= 2'h0;
            sub_off_ff   <= 2'h0;
            diag_code_ff <= `SSI_DIAG_NONE;
            scan_en_ff   <= 1'b0;
            for (i = 0; i < 2; i = i + 1) begin
                flt_st_ff[i]  <= `SSI_F_OK;
                flt_try_ff[i] <= 2'h0;
                flt_ms_ff[i]  <= 9'h000;
            end
        end else begin
            // Millisecond and second enables from one divider chain.
            ms_tick_ff  <= (tick_cnt_ff == TICK_CYC - 17'h00001);
            tick_cnt_ff <= (tick_cnt_ff == TICK_CYC - 17'h00001) ? 17'h00000
                                                                  : tick_cnt_ff + 17'h00001;
            sec_tick_ff <= 1'b0;
            if (ms_tick_ff) begin
                if (ms_cnt_ff == MS_PER_S - 10'h001) begin
                    ms_cnt_ff   <= 10'h000;
                    sec_tick_ff <= 1'b1;
                end else begin
                    ms_cnt_ff <= ms_cnt_ff + 10'h001;
                end
                if (blink_ms_ff == `SSI_BLINK_MS - 9'h001) begin
                    blink_ms_ff <= 9'h000;
                    blink_ff    <= ~blink_ff;
                end else begin
                    blink_ms_ff <= blink_ms_ff + 9'h001;
                end
                if (gr_ms_ff != 9'h000)
                    gr_ms_ff <= gr_ms_ff - 9'h001;
            end
            if (sec_tick_ff)
                sl_sec_ff <= (sl_sec_ff == SLEEP_S - 4'h1) ? 4'h0 : sl_sec_ff + 4'h1;
            if (run && good_read)
                gr_ms_ff <= `SSI_FLASH_MS;
            cfg_d_ff <= cfg_mode;

            case (st_ff)
                `SSI_ST_BOOT: begin
                    if (selftest_done) begin
                        st_ff       <= selftest_elec_fail ? `SSI_ST_FAIL : `SSI_ST_RUN;
                        nvm_err_ff  <= selftest_nvm_fail;
                        laser_en_ff <= !selftest_elec_fail;
                        motor_en_ff <= !selftest_elec_fail;
                    end
                end
                `SSI_ST_RUN: begin
                    // Power save: laser first, motor after a further idle stretch.
                    if (ir_motion) begin
                        laser_en_ff <= 1'b1;
                        motor_en_ff <= 1'b1;
                        idle_s_ff   <= 16'h0000;
                        motor_s_ff  <= 11'h000;
                    end else if (good_read || cfg_mode || prog_mode) begin
                        idle_s_ff  <= 16'h0000;
                    end else if (sec_tick_ff) begin
                        if (laser_en_ff) begin
                            if (idle_s_ff >= idle_limit_s) begin
                                laser_en_ff <= 1'b0;
                                motor_s_ff  <= 11'h000;
                            end else begin
                                idle_s_ff <= idle_s_ff + 16'h0001;
                            end
                        end else if (motor_en_ff) begin
                            if (motor_s_ff == MOTOR_S - 11'h001)
                                motor_en_ff <= 1'b0;
                            else
                                motor_s_ff <= motor_s_ff + 11'h001;
                        end
                    end
                end
                `SSI_ST_FAIL: begin
                    laser_en_ff <= 1'b0;
                    motor_en_ff <= 1'b0;
                end
                default: st_ff <= `SSI_ST_BOOT;
            endcase

            // Retry a failing subsystem, then shut it down and latch.
            recover_ff <= 2'h0;
            for (i = 0; i < 2; i = i + 1) begin
                case (flt_st_ff[i])
                    `SSI_F_OK: begin
                        if (run && sub_fault[i]) begin
                            flt_st_ff[i]  <= `SSI_F_RETRY;
                            flt_try_ff[i] <= 2'h1;
                            flt_ms_ff[i]  <= `SSI_RETRY_MS;
                            recover_ff[i] <= 1'b1;
                        end
                    end
                    `SSI_F_RETRY: begin
                        if (ms_tick_ff) begin
                            if (flt_ms_ff[i] != 9'h000) begin
                                flt_ms_ff[i] <= flt_ms_ff[i] - 9'h001;
                            end else if (!sub_fault[i]) begin
                                flt_st_ff[i] <= `SSI_F_OK;
                            end else if (flt_try_ff[i] == `SSI_RETRY_MAX) begin
                                flt_st_ff[i]  <= `SSI_F_DOWN;
                                sub_off_ff[i] <= 1'b1;
                            end else begin
                                flt_try_ff[i] <= flt_try_ff[i] + 2'h1;
                                flt_ms_ff[i]  <= `SSI_RETRY_MS;
                                recover_ff[i] <= 1'b1;
                            end
                        end
                    end
                    `SSI_F_DOWN: begin
                        if (fault_clear[i]) begin
                            flt_st_ff[i]  <= `SSI_F_OK;
                            sub_off_ff[i] <= 1'b0;
                        end
                    end
                    default: flt_st_ff[i] <= `SSI_F_OK;
                endcase
            end

            // Pattern sequencer; a new request set in the take cycle survives.
            pend_ff <= pend_ff | req;
            if (st_ff == `SSI_ST_FAIL) begin
                bp_busy_ff   <= 1'b0;
                beep_en_ff   <= 1'b1;
                beep_tone_ff <= `SSI_TONE_BUZZ;
            end else if (!bp_busy_ff) begin
                if (pend_ff != 8'h00) begin
                    pend_ff    <= (pend_ff & ~(8'h01 << pick)) | req;
                    bp_busy_ff <= 1'b1;
                    bp_pat_ff  <= pick;
                    bp_idx_ff  <= 3'h0;
                    bp_ms_ff   <= 9'h000;
                end
                beep_en_ff <= 1'b0;
            end else begin
                beep_tone_ff <= cur[5:2];
                beep_en_ff   <= cur[6] && cur[5:2] != `SSI_TONE_SILENT;
                if (ms_tick_ff) begin
                    if (bp_ms_ff >= dur_ms(cur[1:0]) - 9'h001) begin
                        bp_ms_ff <= 9'h000;
                        if (cur[7]) begin
                            bp_busy_ff <= 1'b0;
                            beep_en_ff <= 1'b0;
                        end else begin
                            bp_idx_ff <= bp_idx_ff + 3'h1;
                        end
                    end else begin
                        bp_ms_ff <= bp_ms_ff + 9'h001;
                    end
                end
            end
            beep_vol_ff <= (vol_sel > `SSI_VOL_MAX) ? `SSI_VOL_MAX : vol_sel;

            // Diagnostic code, most severe source first.
            if (flt_st_ff[1] != `SSI_F_OK)
                diag_code_ff <= `SSI_DIAG_MOTOR;
            else if (flt_st_ff[0] != `SSI_F_OK)
                diag_code_ff <= `SSI_DIAG_LASER;
            else if (nvm_err_ff)
                diag_code_ff <= `SSI_DIAG_CFG;
            else
                diag_code_ff <= ext_diag_code;

            led_white_ff <= nxt_white;
            led_blue_ff  <= nxt_blue;
            // Scanning goes on with whichever subsystem remains.
            scan_en_ff   <= run && laser_en_ff && motor_en_ff && (sub_off_ff != 2'h3);
        end
    end
endmodule
`default_nettype wire

// file: test/ssi_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssi_regs.vh"
module ssi_ctrl_checker (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       selftest_done,
    input wire logic       selftest_elec_fail,
    input wire logic       cfg_mode,
    input wire logic       prog_mode,
    input wire logic       host_wait,
    input wire logic       sleep_mode,
    input wire logic       ir_motion,
    input wire logic [1:0] sub_fault,
    input wire logic [1:0] fault_clear,
    input wire logic       led_white_ff,
    input wire logic       led_blue_ff,
    input wire logic       beep_en_ff,
    input wire logic [3:0] beep_tone_ff,
    input wire logic [1:0] beep_vol_ff,
    input wire logic       laser_en_ff,
    input wire logic       motor_en_ff,
    input wire logic [1:0] recover_ff,
    input wire logic [1:0] sub_off_ff,
    input wire logic [7:0] diag_code_ff,
    input wire logic       scan_en_ff
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Lamps are registered after arbitration, so darkness is judged one cycle late.
    property p_dark;
        (!laser_en_ff && !sleep_mode) [*3] |=> (!led_white_ff && !led_blue_ff);
    endproperty
    a_dark: assert property (p_dark) else $error("lamps lit with lasers off");
    property p_fail;
        selftest_done && selftest_elec_fail |-> ##4 (beep_en_ff && !scan_en_ff
            && beep_tone_ff == `SSI_TONE_BUZZ && !led_white_ff && !led_blue_ff) [*8];
    endproperty
    a_fail: assert property (p_fail) else $error("no steady buzz on failure");
    property p_retry;
        $rose(sub_fault[0]) && scan_en_ff && sub_off_ff == 2'h0 |=> recover_ff[0];
    endproperty
    a_retry: assert property (p_retry) else $error("no recovery try");
    property p_pulse;
        recover_ff[0] |=> !recover_ff[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("recovery pulse too long");
    property p_latch;
        sub_off_ff[0] && !fault_clear[0] |=> sub_off_ff[0];
    endproperty
    a_latch: assert property (p_latch) else $error("shutdown not latched");
    property p_lcode;
        $rose(sub_off_ff[0]) |-> ##[0:2] diag_code_ff == `SSI_DIAG_LASER;
    endproperty
    a_lcode: assert property (p_lcode) else $error("laser code missing");
    property p_mcode;
        $rose(sub_off_ff[1]) |-> ##[0:2] diag_code_ff == `SSI_DIAG_MOTOR;
    endproperty
    a_mcode: assert property (p_mcode) else $error("motor code missing");
    property p_vol;
        $rose(beep_en_ff) |-> (beep_vol_ff <= `SSI_VOL_MAX) [*3];
    endproperty
    a_vol: assert property (p_vol) else $error("volume out of range");
    property p_wait;
        (host_wait && laser_en_ff && scan_en_ff && !sleep_mode && !cfg_mode && !prog_mode
            && sub_fault == 2'h0 && sub_off_ff == 2'h0 && diag_code_ff == 8'h00) [*3]
            |=> (led_white_ff && !led_blue_ff);
    endproperty
    a_wait: assert property (p_wait) else $error("wrong host wait lamps");
    property p_wake;
        ir_motion && sub_off_ff == 2'h0 |-> ##[1:3] (laser_en_ff && motor_en_ff);
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on motion");
endmodule
bind ssi_ctrl ssi_ctrl_checker u_ssi_ctrl_checker (.mclk(mclk), .rst(rst),
    .selftest_done(selftest_done), .selftest_elec_fail(selftest_elec_fail),
    .cfg_mode(cfg_mode), .prog_mode(prog_mode), .host_wait(host_wait),
    .sleep_mode(sleep_mode), .ir_motion(ir_motion), .sub_fault(sub_fault),
    .fault_clear(fault_clear), .led_white_ff(led_white_ff), .led_blue_ff(led_blue_ff),
    .beep_en_ff(beep_en_ff), .beep_tone_ff(beep_tone_ff), .beep_vol_ff(beep_vol_ff),
    .laser_en_ff(laser_en_ff), .motor_en_ff(motor_en_ff), .recover_ff(recover_ff),
    .sub_off_ff(sub_off_ff), .diag_code_ff(diag_code_ff), .scan_en_ff(scan_en_ff));
`default_nettype wire

// file: test/ssi_operator_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_operator_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       led_white_ff,
    input  wire logic       beep_en_ff,
    input  wire logic [3:0] beep_tone_ff,
    output var  logic [7:0] beeps,
    output var  logic [7:0] whites,
    output var  logic [3:0] tone_last,
    output var  logic [3:0] tone_prev
);
    logic beep_d;
    logic white_d;
    // A tone change with no gap counts as a new tone, so gapless sweeps are seen.
    always @(posedge mclk) begin
        beep_d <= beep_en_ff;
        white_d <= led_white_ff;
        if (rst) begin
            beeps <= 8'h00;
            whites <= 8'h00;
        end else begin
            if (beep_en_ff && (!beep_d || beep_tone_ff != tone_last)) begin
                beeps <= beeps + 8'h01;
                tone_prev <= tone_last;
                tone_last <= beep_tone_ff;
            end
            if (led_white_ff && !white_d) begin
                whites <= whites + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/ssi_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssi_regs.vh"
`define SSI_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module ssi_ctrl_bench;
    logic        mclk, rst, st_elec, st_nvm, beep_rd, cfg_mode, prog_mode, to_en;
    logic        pending, host_ready, host_wait, sleep;
    logic [7:0]  ev, beeps, whites, b0, w0;
    logic [15:0] idle_s;
    logic [1:0]  sub_fault, fclr, recover, sub_off;
    logic [3:0]  tone, t_last, t_prev;
    logic [1:0]  vol;
    logic [7:0]  diag;
    logic        white, blue, beep_en, laser, motor, scan;
    int          n_fail, num_checks;
    // Short ticks keep the thirty-minute motor wait near nine thousand cycles.
    ssi_ctrl #(.TICK_CYC(17'd5), .MS_PER_S(10'd1)) u_ssi_ctrl (.mclk(mclk), .rst(rst),
        .selftest_done(ev[6]), .selftest_elec_fail(st_elec), .selftest_nvm_fail(st_nvm),
        .good_read(ev[0]), .beep_on_read_en(beep_rd), .cfg_mode(cfg_mode),
        .prog_mode(prog_mode), .invalid_code(ev[1]), .host_timeout(ev[2]),
        .host_timeout_beep_en(to_en), .one_code_ok(ev[3]), .flash_main(ev[4]),
        .flash_cop(ev[5]), .data_pending(pending), .host_ready(host_ready),
        .host_wait(host_wait), .sleep_mode(sleep), .ir_motion(ev[7]), .idle_limit_s(idle_s),
        .tone_sel(3'h2), .vol_sel(2'h3), .sub_fault(sub_fault), .fault_clear(fclr),
        .ext_diag_code(8'h00), .led_white_ff(white), .led_blue_ff(blue),
        .beep_en_ff(beep_en), .beep_tone_ff(tone), .beep_vol_ff(vol), .laser_en_ff(laser),
        .motor_en_ff(motor), .recover_ff(recover), .sub_off_ff(sub_off),
        .diag_code_ff(diag), .scan_en_ff(scan));
    ssi_operator_model u_ssi_operator_model (.mclk(mclk), .rst(rst), .led_white_ff(white),
        .beep_en_ff(beep_en), .beep_tone_ff(tone), .beeps(beeps), .whites(whites),
        .tone_last(t_last), .tone_prev(t_prev));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task pulse(input int b);
        ev[b] = 1'b1;
        step(1);
        ev[b] = 1'b0;
    endtask
    task do_reset;
        rst = 1'b1;
        step(16);
        rst = 1'b0;
    endtask
    task beeps_in(input int n, input int cyc);
        b0 = beeps;
        step(cyc);
        `SSI_CHK(8'(beeps - b0), 8'(n))
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {rst, st_elec, st_nvm, beep_rd, cfg_mode, prog_mode, to_en, sleep} = 8'h00;
        {pending, host_ready, host_wait, ev, sub_fault, fclr} = 15'h0000;
        idle_s = 16'hFFFF;
        n_fail = 0;
        num_checks = 0;
        do_reset;
        pulse(6);
        beeps_in(1, 1500);
        `SSI_CHK({blue, scan, whites >= 8'h01}, 3'h7)
        $display("boot done");
        beep_rd = 1'b1;
        w0 = whites;
        pulse(0);
        beeps_in(1, 200);
        `SSI_CHK({beep_en, vol}, 3'h6)
        step(800);
        beep_rd = 1'b0;
        pulse(0);
        beeps_in(0, 1000);
        `SSI_CHK(8'(whites - w0), 8'h02)
        $display("good read done");
        cfg_mode = 1'b1;
        beeps_in(3, 4000);
        cfg_mode = 1'b0;
        beeps_in(3, 4000);
        to_en = 1'b1;
        pulse(2);
        beeps_in(3, 4000);
        $display("three beep patterns done");
        pulse(3);
        beeps_in(5, 6000);
        `SSI_CHK({t_prev, t_last}, {`SSI_TONE_HIGH, `SSI_TONE_LOW})
        pulse(4);
        step(5000);
        `SSI_CHK(t_prev > t_last, 1'b1)
        pulse(5);
        step(5000);
        `SSI_CHK(t_last > t_prev, 1'b1)
        prog_mode = 1'b1;
        pulse(1);
        step(200);
        `SSI_CHK(tone, `SSI_TONE_BUZZ)
        step(3000);
        prog_mode = 1'b0;
        $display("tones done");
        host_wait = 1'b1;
        step(20);
        `SSI_CHK({white, blue}, 2'h2)
        host_wait = 1'b0;
        pending = 1'b1;
        step(20);
        `SSI_CHK(white, 1'b1)
        host_ready = 1'b1;
        step(20);
        `SSI_CHK({white, blue}, 2'h1)
        pending = 1'b0;
        $display("host lamps done");
        sub_fault = 2'h1;
        step(11000);
        `SSI_CHK({sub_off, diag, scan}, {2'h1, `SSI_DIAG_LASER, 1'b1})
        sub_fault = 2'h0;
        fclr = 2'h1;
        step(1);
        fclr = 2'h0;
        step(20);
        `SSI_CHK(sub_off, 2'h0)
        sub_fault = 2'h2;
        step(11000);
        `SSI_CHK({sub_off, diag}, {2'h2, `SSI_DIAG_MOTOR})
        sub_fault = 2'h0;
        fclr = 2'h2;
        step(1);
        fclr = 2'h0;
        step(3000);
        $display("faults done");
        pulse(0);
        idle_s = 16'h0002;
        step(50);
        `SSI_CHK({laser, motor, white, blue}, 4'h4)
        step(9500);
        `SSI_CHK(motor, 1'b0)
        idle_s = 16'hFFFF;
        pulse(7);
        step(4);
        `SSI_CHK({laser, motor}, 2'h3)
        $display("power save done");
        sleep = 1'b1;
        step(10);
        w0 = whites;
        step(150);
        `SSI_CHK(8'(whites - w0), 8'h02)
        sleep = 1'b0;
        $display("sleep done");
        do_reset;
        st_nvm = 1'b1;
        pulse(6);
        b0 = beeps;
        step(6000);
        `SSI_CHK({8'(beeps - b0) >= 8'h03, diag}, {1'b1, `SSI_DIAG_CFG})
        st_nvm = 1'b0;
        do_reset;
        st_elec = 1'b1;
        pulse(6);
        step(20);
        `SSI_CHK({beep_en, tone, white, blue, scan}, {1'b1, `SSI_TONE_BUZZ, 3'h0})
        $display("self check done");
        end_sim;
    end
    initial begin
        repeat (95000) @(posedge mclk);
        n_fail++;
        end_sim;
    end
endmodule
`default_nettype wire
